/* File: src/farc_top.sv */
`timescale 1ns/10ps
`include "farc_regs.svh"
// Overview of operation
// - any reset restores defaults, refreshes, hi-z output
// - reset pin low pulse starts full reset
// - key1 then key2 writes cause software reset
// - overheat reset only when enable bit set
// - hold reset while core supply low
// - set reset-done flag after each reset
// - bus access during reset sets memory error
// - alert pin asserts on unmasked condition
// - latched status bits are sticky
// - write one clears, zero keeps
// - supply summary stays while supply flag set
// - live register follows conditions unlatched
// - mask bit blocks its condition from pin
// - six supply monitors set own bits
// - overheat alert sets flag regardless
// - alert pin active low
// - pin released once flags cleared
module farc_top #(
  parameter int RESET_CYCLES = `FARC_RESET_CYCLES
) (
  // clock and reset
  input  wire logic                sys_clk_i,
  input  wire logic                rst_i,
  // pins and monitors
  input  wire logic                reset_n_i,
  input  wire farc_pkg::farc_cond_s cond_i,
  input  wire logic [1:0]          core_supply_low_i,
  output logic                     alert_n_o,
  output logic                     out_hiz_o,
  output logic                     cal_refresh_o,
  output logic                     in_reset_o,
  // apb slave
  input  wire logic                psel_i,
  input  wire logic                penable_i,
  input  wire logic                pwrite_i,
  input  wire logic [11:0]         paddr_i,
  input  wire logic [31:0]         pwdata_i,
  output logic [31:0]              prdata_o,
  output logic                     pready_o,
  output logic                     pslverr_o
);
  // refused at elaboration: a zero count wraps the end compare and stretches the hold to 2**32 cycles
  if (RESET_CYCLES < 1)
  begin : g_bad_reset_cycles
    $error("RESET_CYCLES must be at least one");
  end

  // ---------------------------------------------------------------
  // input synchronisers: three stages, second and third must agree
  // ---------------------------------------------------------------
  localparam int NS = 8 + 1 + 2;
  // stages start at each pin's rest level, so leaving rst_i is no edge
  localparam logic [NS-1:0] SYNC_IDLE = 11'h004;
  logic [NS-1:0] raw, s1_q, s2_q, s3_q, filt_q, filt_d;
  // conditions on top, then the reset pin, then the two core monitors
  assign raw = {cond_i, reset_n_i, core_supply_low_i};

  // a bit moves only once the last two stages agree; a split vote holds
  always_comb
  begin
    filt_d = filt_q;
    for (int i = 0; i < NS; i++)
      if (s2_q[i] == s3_q[i])
        filt_d[i] = s3_q[i];
  end

  // three stages plus the filtered copy
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      s1_q   <= SYNC_IDLE;
      s2_q   <= SYNC_IDLE;
      s3_q   <= SYNC_IDLE;
      filt_q <= SYNC_IDLE;  // reset pin idles high
    end
    else
    begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= filt_d;
    end
  end

  // filtered views; either core monitor low holds the device in reset
  farc_pkg::farc_cond_s cond;
  logic pin_n, core_low;
  assign cond     = filt_q[10:3];
  assign pin_n    = filt_q[2];
  assign core_low = |filt_q[1:0];

  // ---------------------------------------------------------------
  // reset sequencer
  // ---------------------------------------------------------------
  // state and the hold counter
  farc_pkg::farc_seq_e seq_q, seq_d;
  logic [31:0] cnt_q, cnt_d;
  logic        ovht_en_q, key1_q, soft_rst, start_rst;
  // any source restarts the cycle; supply low keeps it held
  assign start_rst = !pin_n
                   | soft_rst
                   | (ovht_en_q & cond.overheat_reset)
                   | core_low;

  // next state: a restart zeroes the count, hold ends after the full count
  always_comb
  begin
    seq_d = seq_q;
    cnt_d = cnt_q;
    if (start_rst)
    begin
      seq_d = farc_pkg::FARC_HOLD;
      cnt_d = '0;
    end
    else
    begin
      unique case (seq_q)
        farc_pkg::FARC_RUN:  seq_d = farc_pkg::FARC_RUN;
        farc_pkg::FARC_HOLD:
        begin
          cnt_d = cnt_q + 32'h00000001;
          if (cnt_q >= 32'(RESET_CYCLES - 1))
            seq_d = farc_pkg::FARC_DONE;
        end
        farc_pkg::FARC_DONE: seq_d = farc_pkg::FARC_RUN;
        default:             seq_d = farc_pkg::FARC_HOLD;
      endcase
    end
  end

  // power-up lands in hold, so every start runs one full cycle
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      seq_q <= farc_pkg::FARC_HOLD;
      cnt_q <= '0;
    end
    else
    begin
      seq_q <= seq_d;
      cnt_q <= cnt_d;
    end
  end

  // outputs decode the state and stand for the whole hold
  logic in_rst, rst_done;
  assign in_rst   = (seq_q == farc_pkg::FARC_HOLD);
  assign rst_done = (seq_q == farc_pkg::FARC_DONE);
  assign in_reset_o    = in_rst;
  assign cal_refresh_o = in_rst;
  assign out_hiz_o     = in_rst;

  // ---------------------------------------------------------------
  // apb decode; zero wait states, unmapped address gives pslverr
  // ---------------------------------------------------------------
  logic acc, wr, rd, hit_st, hit_sup, hit_live, hit_mask, hit_key, hit_ovr;
  // access-phase strobes; each hit line decodes one exact 12-bit address
  assign acc      = psel_i & penable_i;
  assign wr       = acc & pwrite_i & !in_rst;  // registers frozen in reset
  assign rd       = acc & !pwrite_i;
  assign hit_st   = paddr_i == `FARC_ALERT_STATUS_OFS;
  assign hit_sup  = paddr_i == `FARC_SUPPLY_STATUS_OFS;
  assign hit_live = paddr_i == `FARC_LIVE_STATUS_OFS;
  assign hit_mask = paddr_i == `FARC_ALERT_MASK_OFS;
  assign hit_key  = paddr_i == `FARC_CMD_KEY_OFS;
  assign hit_ovr  = paddr_i == `FARC_OVERHEAT_RST_OFS;

  // every register answers in its access cycle, so no wait states
  assign pready_o = 1'b1;
  assign pslverr_o = acc & !(hit_st | hit_sup | hit_live | hit_mask | hit_key | hit_ovr);

  // ---------------------------------------------------------------
  // status, mask, key and enable registers
  // ---------------------------------------------------------------
  // latched flags, mask and the key and enable state
  localparam int SW = `FARC_STATUS_W;
  logic [SW-1:0] st_q, st_d, mask_q, mask_d, live;
  logic          sup_q, sup_d, key1_d, ovht_en_d;
  logic [15:0]   wkey;
  assign wkey = pwdata_i[15:0];
  // live view; conditions unlatched, summary bit taken from sup_q
  always_comb
  begin
    live = '0;
    live[`FARC_BIT_SUPPLY0 +: `FARC_NUM_SUPPLY] = cond.supply_low;
    live[`FARC_BIT_OVERHEAT]   = cond.overheat_alert;
    live[`FARC_BIT_SUPPLY_SUM] = sup_q;
  end

  // the second key only counts on the next key-register write after the first
  assign soft_rst = wr & hit_key & key1_q & (wkey == `FARC_KEY2);

  // next values for flags and configuration
  always_comb
  begin
    st_d      = st_q;
    sup_d     = sup_q;
    mask_d    = mask_q;
    key1_d    = key1_q;
    ovht_en_d = ovht_en_q;
    // clears first so that a same-cycle event wins
    if (wr & hit_st)
      st_d = st_q & ~pwdata_i[SW-1:0];
    if (wr & hit_sup & pwdata_i[`FARC_BIT_CAL_MEM_ERR])
      sup_d = 1'b0;
    if (wr & hit_mask)
      mask_d = pwdata_i[SW-1:0];
    if (wr & hit_ovr)
      ovht_en_d = pwdata_i[`FARC_BIT_OVHT_RST_EN];
    if (wr & hit_key)
      key1_d = (wkey == `FARC_KEY1);
    // sticky sets
    st_d[`FARC_BIT_SUPPLY0 +: `FARC_NUM_SUPPLY] =
      st_d[`FARC_BIT_SUPPLY0 +: `FARC_NUM_SUPPLY] | cond.supply_low;
    if (cond.overheat_alert)
      st_d[`FARC_BIT_OVERHEAT] = 1'b1;
    if (rst_done)
      st_d[`FARC_BIT_RESET_DONE] = 1'b1;
    if (acc & in_rst)
      sup_d = 1'b1;
    if (sup_d)
      st_d[`FARC_BIT_SUPPLY_SUM] = 1'b1;
    // any reset cycle returns configuration to defaults
    if (in_rst)
    begin
      mask_d    = `FARC_MASK_RESET;
      key1_d    = 1'b0;
      ovht_en_d = 1'b0;
      st_d      = st_d & (SW'(1) << `FARC_BIT_SUPPLY_SUM);
    end
  end

  // registers only; every decision sits in the process above
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q      <= '0;
      sup_q     <= 1'b0;
      mask_q    <= `FARC_MASK_RESET;
      key1_q    <= 1'b0;
      ovht_en_q <= 1'b0;
    end
    else
    begin
      st_q      <= st_d;
      sup_q     <= sup_d;
      mask_q    <= mask_d;
      key1_q    <= key1_d;
      ovht_en_q <= ovht_en_d;
    end
  end

  // ---------------------------------------------------------------
  // alert pin: combinational, active low
  // ---------------------------------------------------------------
  // masked flags still latch; only the pin ignores them
  assign alert_n_o = !(|(st_q & ~mask_q));

  // ---------------------------------------------------------------
  // read data, registered at the setup edge
  // ---------------------------------------------------------------
  logic [31:0] rdata_q, rdata_d;
  // loaded at the setup edge so it already stands in the access cycle
  always_comb
  begin
    rdata_d = rdata_q;
    if (psel_i & !penable_i & !pwrite_i)
    begin
      rdata_d = '0;
      if (hit_st)
        rdata_d[SW-1:0] = st_q;
      if (hit_sup)
        rdata_d[0] = sup_q;
      if (hit_live)
        rdata_d[SW-1:0] = live;
      if (hit_mask)
        rdata_d[SW-1:0] = mask_q;
      if (hit_ovr)
        rdata_d[0] = ovht_en_q;
    end
  end

  // unread bits stay zero; data holds until the next read setup
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_q <= '0;
    else
      rdata_q <= rdata_d;
  end

  // output straight from the register
  assign prdata_o = rdata_q;
endmodule : farc_top

/* File: src/farc_regs.svh */
`ifndef FARC_REGS_SVH
`define FARC_REGS_SVH
// ---------------------------------------------------------------
// register map (byte addresses)
// ---------------------------------------------------------------
`define FARC_ALERT_STATUS_OFS   12'h000
`define FARC_SUPPLY_STATUS_OFS  12'h004
`define FARC_LIVE_STATUS_OFS    12'h008
`define FARC_ALERT_MASK_OFS     12'h00C
`define FARC_CMD_KEY_OFS        12'h010
`define FARC_OVERHEAT_RST_OFS   12'h014
// ---------------------------------------------------------------
// field positions in the latched/live/mask layout and in the one-bit supply and overheat registers
// ---------------------------------------------------------------
`define FARC_BIT_RESET_DONE     0
`define FARC_BIT_SUPPLY0        1
`define FARC_BIT_OVERHEAT       7
`define FARC_BIT_SUPPLY_SUM     8
`define FARC_NUM_SUPPLY         6
`define FARC_STATUS_W           9
`define FARC_BIT_CAL_MEM_ERR    0
`define FARC_BIT_OVHT_RST_EN    0
// ---------------------------------------------------------------
// keys, reset values, timing
// ---------------------------------------------------------------
`define FARC_KEY1               16'h15FA
`define FARC_KEY2               16'hAF51
`define FARC_MASK_RESET         9'h000
`define FARC_RESET_TIME_US      100
`define FARC_CLK_MHZ            25
`define FARC_RESET_CYCLES       (`FARC_RESET_TIME_US * `FARC_CLK_MHZ)
`endif

/* File: src/farc_pkg.sv */
package farc_pkg;
  typedef enum logic [1:0]
  {
    FARC_RUN  = 2'b00,
    FARC_HOLD = 2'b01,
    FARC_DONE = 2'b10
  } farc_seq_e;
  typedef struct packed
  {
    logic [5:0] supply_low;
    logic       overheat_alert;
    logic       overheat_reset;
  } farc_cond_s;
endpackage : farc_pkg

/* File: verif/farc_props.sv */
`timescale 1ns/10ps
`include "farc_regs.svh"
// ------------------------------
// fault and reset checker
// ------------------------------
module farc_props #(
  parameter int RESET_CYCLES = `FARC_RESET_CYCLES
) (
  // clock, reset and pins
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic                 reset_n_i,
  input wire farc_pkg::farc_cond_s cond_i,
  input wire logic [1:0]           core_supply_low_i,
  input wire logic                 alert_n_o,
  input wire logic                 out_hiz_o,
  input wire logic                 cal_refresh_o,
  input wire logic                 in_reset_o,
  // apb
  input wire logic                 psel_i,
  input wire logic                 penable_i,
  input wire logic                 pwrite_i,
  input wire logic [11:0]          paddr_i,
  input wire logic [31:0]          pwdata_i
);
  logic        wr;
  logic        key1_q;
  logic        en_q;
  logic        msk_q;
  logic [15:0] len_q;
  // writes during reset are dropped, so they never arm anything here
  assign wr = psel_i && penable_i && pwrite_i && !in_reset_o;
  // shadow of key, enable and mask bit 1, wiped by every reset
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      {key1_q, en_q, msk_q, len_q} <= '0;
    else
    begin
      // saturates, so a long supply hold never wraps the count
      len_q <= !in_reset_o ? 16'h0000 : (&len_q) ? len_q : len_q + 16'h0001;
      if (in_reset_o)
        {key1_q, en_q, msk_q} <= 3'b000;
      else if (wr && paddr_i == `FARC_CMD_KEY_OFS)
        key1_q <= (pwdata_i[15:0] == `FARC_KEY1);
      else if (wr && paddr_i == `FARC_OVERHEAT_RST_OFS)
        en_q <= pwdata_i[0];
      else if (wr && paddr_i == `FARC_ALERT_MASK_OFS)
        msk_q <= pwdata_i[1];
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  chk_reset_outputs: assert property (in_reset_o == out_hiz_o && in_reset_o == cal_refresh_o)
    else $error("output not safe around reset");
  chk_reset_length: assert property ($fell(in_reset_o) |-> len_q >= RESET_CYCLES)
    else $error("reset cycle too short");
  chk_pin_reset: assert property (!reset_n_i [*2] |-> ##[1:6] in_reset_o)
    else $error("pin pulse gave no reset");
  chk_soft_reset: assert property (wr && paddr_i == `FARC_CMD_KEY_OFS && key1_q
    && pwdata_i[15:0] == `FARC_KEY2 |-> ##[1:3] in_reset_o) else $error("key pair gave no reset");
  chk_heat_reset: assert property ((en_q && cond_i.overheat_reset) [*4] |-> ##[0:3] in_reset_o)
    else $error("overheat gave no reset");
  chk_core_hold: assert property ((|core_supply_low_i) [*6] |-> in_reset_o)
    else $error("core supply low outside reset");
  chk_done_alert: assert property ($fell(in_reset_o) |-> ##[0:2] !alert_n_o)
    else $error("no alert after reset");
  chk_unmasked_alert: assert property ((!msk_q && !in_reset_o && cond_i.supply_low[0]) [*6]
    |-> !alert_n_o) else $error("unmasked supply fault gave no alert");
  cover property ($fell(in_reset_o));
  cover property (wr && paddr_i == `FARC_ALERT_MASK_OFS);
  cover property (!alert_n_o ##1 alert_n_o);
endmodule : farc_props
bind farc_top farc_props #(.RESET_CYCLES(RESET_CYCLES)) u_props (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .cond_i(cond_i),
  .core_supply_low_i(core_supply_low_i), .alert_n_o(alert_n_o), .out_hiz_o(out_hiz_o),
  .cal_refresh_o(cal_refresh_o), .in_reset_o(in_reset_o), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i));

/* File: verif/farc_host.sv */
`timescale 1ns/10ps
// ------------------------------
// apb host model
// ------------------------------
module farc_host (
  // bus
  input  wire logic        clk_i,
  input  wire logic        pready_i,
  input  wire logic        pslverr_i,
  input  wire logic [31:0] prdata_i,
  output logic             psel_o,
  output logic             penable_o,
  output logic             pwrite_o,
  output logic [11:0]      paddr_o,
  output logic [31:0]      pwdata_o
);
  // bus idle from time zero
  initial
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} = '0;
  // one transfer, held until pready is seen at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    @(posedge clk_i);
    {psel_o, penable_o, pwrite_o, paddr_o, pwdata_o} <= {2'b10, w, a, d};
    @(posedge clk_i);
    penable_o <= 1'b1;
    do @(posedge clk_i); while (pready_i !== 1'b1);
    r = prdata_i;
    e = pslverr_i;
    {psel_o, penable_o} <= 2'b00;
    pwdata_o <= ~d; // released data must not look valid
  endtask : xfer
endmodule : farc_host

/* File: verif/tb.sv */
`timescale 1ns/10ps
`include "farc_regs.svh"
// ------------------------------
// fault block bench
// ------------------------------
module tb;
  localparam logic [11:0] ST = `FARC_ALERT_STATUS_OFS, SP = `FARC_SUPPLY_STATUS_OFS;
  localparam logic [11:0] LV = `FARC_LIVE_STATUS_OFS, MK = `FARC_ALERT_MASK_OFS;
  localparam logic [11:0] CK = `FARC_CMD_KEY_OFS, OV = `FARC_OVERHEAT_RST_OFS;
  logic sys_clk_i, rst_i, reset_n_i, alert_n_o, out_hiz_o, cal_refresh_o, in_reset_o;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, err_q;
  logic [1:0] core_supply_low_i;
  logic [11:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd_q;
  farc_pkg::farc_cond_s cond_i;
  int miscompares = 0;
  int samples_checked = 0;
  // short reset count keeps the run brief
  farc_top #(.RESET_CYCLES(8)) dut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reset_n_i(reset_n_i), .cond_i(cond_i),
    .core_supply_low_i(core_supply_low_i), .alert_n_o(alert_n_o), .out_hiz_o(out_hiz_o),
    .cal_refresh_o(cal_refresh_o), .in_reset_o(in_reset_o), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  farc_host host (.clk_i(sys_clk_i), .pready_i(pready_o), .pslverr_i(pslverr_o),
    .prdata_i(prdata_o), .psel_o(psel_i), .penable_o(penable_i), .pwrite_o(pwrite_i),
    .paddr_o(paddr_i), .pwdata_o(pwdata_i));
  // 25 mhz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  // hang guard, far past the expected run
  initial
  begin
    #100000;
    miscompares++;
    results();
  end
  task results;
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, rd_q, err_q);
  endtask : wr
  task rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0000_0000, rd_q, err_q);
  endtask : rd
  // let the edge's updates land before looking
  task tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  task wait_rst(input logic lvl);
    for (int i = 0; i < 100 && in_reset_o !== lvl; i++) tick(1);
    chk(in_reset_o, lvl);
  endtask : wait_rst
  // supply flags go first, the summary would re-set otherwise
  task clr;
    wr(SP, 32'h1);
    wr(ST, 32'hFFFF);
  endtask : clr
  task t_por;
    wait_rst(1'b0);
    chk(out_hiz_o, 1'b0);
    rd(ST);
    chk(rd_q, 32'h1);
    chk(alert_n_o, 1'b0);
    rd(12'h020);
    chk(err_q, 1'b1);
    clr();
    rd(ST);
    chk(rd_q, 32'h0);
    chk(alert_n_o, 1'b1);
    $display("t_por done");
  endtask : t_por
  task t_supply;
    for (int i = 0; i < 6; i++)
    begin
      cond_i.supply_low <= 6'h01 << i;
      tick(5);
      rd(LV);
      chk(rd_q, 32'h2 << i);
      chk(alert_n_o, 1'b0);
      cond_i.supply_low <= 6'h00;
      tick(5);
      rd(LV);
      chk(rd_q, 32'h0);
      wr(ST, 32'h0);
      rd(ST);
      chk(rd_q, 32'h2 << i);
      wr(ST, 32'h2 << i);
      rd(ST);
      chk(rd_q, 32'h0);
    end
    $display("t_supply done");
  endtask : t_supply
  task t_mask;
    wr(MK, 32'h80);
    cond_i.overheat_alert <= 1'b1;
    tick(5);
    cond_i.overheat_alert <= 1'b0;
    rd(ST);
    chk(rd_q, 32'h80);
    chk(alert_n_o, 1'b1);
    wr(MK, 32'h0);
    tick(1);
    chk(alert_n_o, 1'b0);
    wr(ST, 32'h80);
    tick(1);
    chk(alert_n_o, 1'b1);
    $display("t_mask done");
  endtask : t_mask
  task t_soft;
    wr(MK, 32'h1FF);
    wr(CK, `FARC_KEY1);
    wr(CK, 32'h1234);
    wr(CK, `FARC_KEY2);
    tick(5);
    chk(in_reset_o, 1'b0);
    wr(CK, `FARC_KEY1);
    wr(CK, `FARC_KEY2);
    wait_rst(1'b1);
    chk(cal_refresh_o, 1'b1);
    chk(out_hiz_o, 1'b1);
    rd(ST);
    wait_rst(1'b0);
    chk(cal_refresh_o, 1'b0);
    rd(SP);
    chk(rd_q, 32'h1);
    rd(ST);
    chk(rd_q, 32'h101);
    rd(MK);
    chk(rd_q, 32'h0);
    wr(ST, 32'h101);
    rd(ST);
    chk(rd_q, 32'h100);
    clr();
    rd(ST);
    chk(rd_q, 32'h0);
    $display("t_soft done");
  endtask : t_soft
  task t_heat;
    wr(OV, 32'h1);
    rd(OV);
    chk(rd_q, 32'h1);
    wr(OV, 32'h0);
    rd(OV);
    chk(rd_q, 32'h0);
    cond_i.overheat_reset <= 1'b1;
    tick(8);
    chk(in_reset_o, 1'b0);
    wr(OV, 32'h1);
    wait_rst(1'b1);
    cond_i.overheat_reset <= 1'b0;
    wait_rst(1'b0);
    clr();
    $display("t_heat done");
  endtask : t_heat
  task t_pin;
    reset_n_i <= 1'b0;
    tick(2);
    reset_n_i <= 1'b1;
    wait_rst(1'b1);
    wait_rst(1'b0);
    clr();
    $display("t_pin done");
  endtask : t_pin
  task t_core;
    core_supply_low_i <= 2'b01;
    tick(20);
    chk(in_reset_o, 1'b1);
    core_supply_low_i <= 2'b10;
    tick(20);
    chk(in_reset_o, 1'b1);
    core_supply_low_i <= 2'b00;
    wait_rst(1'b0);
    clr();
    $display("t_core done");
  endtask : t_core
  // main sequence
  initial
  begin
    {rst_i, reset_n_i, cond_i, core_supply_low_i} = {2'b11, 10'h000};
    repeat (3) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_por();
    t_supply();
    t_mask();
    t_soft();
    t_heat();
    t_pin();
    t_core();
    results();
  end
endmodule : tb
